// file: rtl/imass_pkg.sv
// Purpose: shared constants and types of the two-wire master ack/stop sequencer
// Assumes: one 20 MHz system clock, Avalon-MM slave with byte addresses
// Notes: rollover period of the baud generator is (reload + 1) system clocks
// Functional notes
// - Setting ack start pulls clock low and puts stored ack value on data.
// - After the ack bit shows, wait one rollover period, then release clock.
// - Once clock reads high, wait one more rollover period, then pull clock low.
// - Ack end: clear ack start, stop the baud generator, return to idle.
// - Buffer write during ack sequence sets write collision, buffer unchanged.
// - After the ninth clock falling edge of a byte, hold clock low.
// - Setting stop start pulls data low; once data reads low, reload and count.
// - On stop timeout release clock, one rollover period later release data.
// - Data read high while clock reads high sets the stop-detected flag.
// - One rollover after stop detection clear stop start and set port interrupt.
// - Buffer write during stop sequence sets write collision, no buffer write.
package imass_pkg;

    localparam int unsigned BRG_W = 16;
    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned TXB_W = 8;
    localparam int unsigned SYNC_W = 2;

    localparam logic [ADDR_W-1:0] OFS_CONTROL = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_BRG = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_MASK = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_TXBUF = 5'h10;

    // Control register fields
    localparam int unsigned CTL_ACK_START = 0;
    localparam int unsigned CTL_ACK_DATA = 1;
    localparam int unsigned CTL_STOP_START = 2;
    localparam int unsigned CTL_SCL_HOLD = 3;
    localparam int unsigned CTL_BUSY = 4;

    // Sticky status and mask fields
    localparam int unsigned ST_W = 3;
    localparam int unsigned ST_STOP = 0;
    localparam int unsigned ST_WRITE_COLLISION_FLAG = 1;
    localparam int unsigned ST_SIRQ = 2;

    localparam logic [BRG_W-1:0] BRG_RESET = 16'h0009;
    localparam logic [ST_W-1:0] MASK_RESET = 3'h0;
    localparam logic [TXB_W-1:0] TXBUF_RESET = 8'h00;
    localparam logic [DATA_W-1:0] RDATA_RESET = 32'h00000000;

    typedef enum logic [3:0] {
        SQ_IDLE,
        SQ_ACK_BIT,
        SQ_ACK_REL,
        SQ_ACK_HIGH,
        SQ_STOP_SDA,
        SQ_STOP_CNT,
        SQ_STOP_SCL,
        SQ_STOP_REL,
        SQ_STOP_TAIL
    } imass_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } imass_lines_t;

    typedef struct packed {
        imass_lines_t s1;
        imass_lines_t s2;
    } imass_sync_t;

    typedef struct packed {
        logic [BRG_W-1:0] cnt;
        logic tick;
    } imass_brg_t;

    typedef struct packed {
        imass_state_t state;
        logic ack_start;
        logic ack_data;
        logic stop_start;
        logic scl_hold;
        logic [BRG_W-1:0] brg_reload;
        logic brg_load;
        logic brg_run;
        logic [TXB_W-1:0] tx_buf;
        logic [ST_W-1:0] status;
        logic [ST_W-1:0] mask;
        logic irq;
        logic scl_rel;
        logic sda_rel;
        logic pin_level;
        logic waitreq;
        logic [DATA_W-1:0] rdata;
    } imass_regs_t;

endpackage

// file: rtl/imass_sync.sv
// Purpose: two-flop synchroniser for the sampled bus line levels
// Assumes: inputs come straight from pins
// Notes: only the second stage may be read by other logic
`timescale 1ns/100ps
module imass_sync
    import imass_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input imass_pkg::imass_lines_t pins,
    output imass_pkg::imass_lines_t lines
);
    imass_sync_t cur;
    imass_sync_t next_cur;

    always_comb
    begin
        next_cur.s1 = pins;
        next_cur.s2 = cur.s1;
    end

    // Released lines idle high, so reset to high avoids a false low
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cur <= '1;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign lines = cur.s2;
endmodule

// file: rtl/imass_brg.sv
// Purpose: baud rate generator producing one tick per rollover period
// Assumes: load and run come from the sequencer on the same clock
// Notes: period is reload + 1 clocks; the counter reloads itself on tick
`timescale 1ns/100ps
module imass_brg
    import imass_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic load,
    input wire logic run,
    input wire logic [imass_pkg::BRG_W-1:0] reload,
    output logic tick
);
    imass_brg_t cur;
    imass_brg_t next_cur;

    always_comb
    begin
        next_cur = cur;
        next_cur.tick = 1'b0;
        if (load)
        begin
            next_cur.cnt = reload;
        end
        else if (run)
        begin
            if (cur.cnt == '0)
            begin
                next_cur.tick = 1'b1;
                next_cur.cnt = reload;
            end
            else
            begin
                next_cur.cnt = cur.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign tick = cur.tick;
endmodule

// file: rtl/imass_top.sv
// Purpose: acknowledge and Stop sequencer of a two-wire bus master
// Assumes: Avalon-MM slave, one cycle wait state, pins open-drain with pull-ups
// Notes: both lines are only pulled low or released, oe_n low means pulling
`timescale 1ns/100ps
module imass_top
    import imass_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [imass_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [imass_pkg::DATA_W-1:0] avs_writedata,
    output logic [imass_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    input wire logic byte_done,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n
);
    imass_regs_t cur;
    imass_regs_t next_cur;
    imass_lines_t pins;
    imass_lines_t lines;
    logic brg_tick;
    logic req;
    logic accept;

    assign pins.scl = scl_in;
    assign pins.sda = sda_in;

    imass_sync u_sync (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .pins(pins),
        .lines(lines)
    );

    imass_brg u_brg (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .load(cur.brg_load),
        .run(cur.brg_run),
        .reload(cur.brg_reload),
        .tick(brg_tick)
    );

    function automatic logic [DATA_W-1:0] read_word(
        input imass_regs_t r,
        input logic [ADDR_W-1:0] a
    );
        logic [DATA_W-1:0] w;
        w = '0;
        if (a == OFS_CONTROL)
        begin
            w[CTL_ACK_START] = r.ack_start;
            w[CTL_ACK_DATA] = r.ack_data;
            w[CTL_STOP_START] = r.stop_start;
            w[CTL_SCL_HOLD] = r.scl_hold;
            w[CTL_BUSY] = (r.state != SQ_IDLE);
        end
        else if (a == OFS_BRG)
        begin
            w[BRG_W-1:0] = r.brg_reload;
        end
        else if (a == OFS_STATUS)
        begin
            w[ST_W-1:0] = r.status;
        end
        else if (a == OFS_MASK)
        begin
            w[ST_W-1:0] = r.mask;
        end
        else if (a == OFS_TXBUF)
        begin
            w[TXB_W-1:0] = r.tx_buf;
        end
        return w;
    endfunction

    // One wait state on every access keeps read data registered
    assign req = avs_read | avs_write;
    assign accept = req & ~cur.waitreq;

    always_comb
    begin
        next_cur = cur;
        // Divider load is a one-cycle strobe
        next_cur.brg_load = 1'b0;

        // Bus handshake: answer one cycle after the request is seen
        if (req && cur.waitreq)
        begin
            next_cur.waitreq = 1'b0;
            next_cur.rdata = read_word(cur, avs_address);
        end
        else
        begin
            next_cur.waitreq = 1'b1;
        end

        // Software writes first, so hardware sets below win over clears
        if (accept && avs_write)
        begin
            if (avs_address == OFS_CONTROL)
            begin
                next_cur.ack_data = avs_writedata[CTL_ACK_DATA];
                // New sequences start only from idle; ack wins if both are set
                if (cur.state == SQ_IDLE)
                begin
                    next_cur.ack_start = avs_writedata[CTL_ACK_START];
                    next_cur.stop_start = avs_writedata[CTL_STOP_START]
                        & ~avs_writedata[CTL_ACK_START];
                end
            end
            else if (avs_address == OFS_BRG)
            begin
                next_cur.brg_reload = avs_writedata[BRG_W-1:0];
            end
            else if (avs_address == OFS_STATUS)
            begin
                next_cur.status = cur.status & ~avs_writedata[ST_W-1:0];
            end
            else if (avs_address == OFS_MASK)
            begin
                next_cur.mask = avs_writedata[ST_W-1:0];
            end
            else if (avs_address == OFS_TXBUF)
            begin
                // A pending start bit counts as busy, so no write slips in before entry
                if (cur.ack_start || cur.stop_start || cur.state != SQ_IDLE)
                begin
                    next_cur.status[ST_WRITE_COLLISION_FLAG] = 1'b1;
                end
                else
                begin
                    next_cur.tx_buf = avs_writedata[TXB_W-1:0];
                end
            end
        end

        // End of a byte: keep the clock pulled low until a sequence moves it
        if (byte_done && cur.state == SQ_IDLE)
        begin
            next_cur.scl_hold = 1'b1;
            next_cur.scl_rel = 1'b0;
        end

        case (cur.state)
            SQ_IDLE:
            begin
                if (cur.ack_start)
                begin
                    // Stored ack value decides ACK (0, pull low) or NACK (1, release)
                    next_cur.scl_rel = 1'b0;
                    next_cur.sda_rel = cur.ack_data;
                    next_cur.brg_load = 1'b1;
                    next_cur.brg_run = 1'b1;
                    next_cur.state = SQ_ACK_BIT;
                end
                else if (cur.stop_start)
                begin
                    next_cur.sda_rel = 1'b0;
                    next_cur.state = SQ_STOP_SDA;
                end
            end
            SQ_ACK_BIT:
            begin
                // Ack bit stands on the data line for one rollover
                if (brg_tick)
                begin
                    next_cur.scl_rel = 1'b1;
                    next_cur.scl_hold = 1'b0;
                    next_cur.brg_run = 1'b0;
                    next_cur.state = SQ_ACK_REL;
                end
            end
            SQ_ACK_REL:
            begin
                // A slave stretching the clock keeps us here
                if (lines.scl)
                begin
                    next_cur.brg_load = 1'b1;
                    next_cur.brg_run = 1'b1;
                    next_cur.state = SQ_ACK_HIGH;
                end
            end
            SQ_ACK_HIGH:
            begin
                // Data line keeps the ack value until the next sequence moves it
                if (brg_tick)
                begin
                    next_cur.scl_rel = 1'b0;
                    next_cur.scl_hold = 1'b1;
                    next_cur.ack_start = 1'b0;
                    next_cur.brg_run = 1'b0;
                    next_cur.state = SQ_IDLE;
                end
            end
            SQ_STOP_SDA:
            begin
                // Divider starts only once the data line really reads low
                if (!lines.sda)
                begin
                    next_cur.brg_load = 1'b1;
                    next_cur.brg_run = 1'b1;
                    next_cur.state = SQ_STOP_CNT;
                end
            end
            SQ_STOP_CNT:
            begin
                // Divider keeps running, so its next tick times the data release
                if (brg_tick)
                begin
                    next_cur.scl_rel = 1'b1;
                    next_cur.scl_hold = 1'b0;
                    next_cur.state = SQ_STOP_SCL;
                end
            end
            SQ_STOP_SCL:
            begin
                // Clock is released; data follows one rollover later
                if (brg_tick)
                begin
                    next_cur.sda_rel = 1'b1;
                    next_cur.brg_run = 1'b0;
                    next_cur.state = SQ_STOP_REL;
                end
            end
            SQ_STOP_REL:
            begin
                // Judged on sampled levels, not on what we drive
                if (lines.sda && lines.scl)
                begin
                    next_cur.status[ST_STOP] = 1'b1;
                    next_cur.brg_load = 1'b1;
                    next_cur.brg_run = 1'b1;
                    next_cur.state = SQ_STOP_TAIL;
                end
            end
            SQ_STOP_TAIL:
            begin
                // Stop start stays set one more rollover after detection
                if (brg_tick)
                begin
                    next_cur.stop_start = 1'b0;
                    next_cur.status[ST_SIRQ] = 1'b1;
                    next_cur.brg_run = 1'b0;
                    next_cur.state = SQ_IDLE;
                end
            end
            default:
            begin
                // Unused codes fall back to idle and leave the lines as they are
                next_cur.state = SQ_IDLE;
            end
        endcase

        // Pins are never driven high; a released line rises by pull-up
        next_cur.pin_level = 1'b0;
        next_cur.irq = |(next_cur.status & next_cur.mask);
    end

    // Reset releases both lines, so the bus sees no false condition
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cur.state <= SQ_IDLE;
            cur.ack_start <= 1'b0;
            cur.ack_data <= 1'b0;
            cur.stop_start <= 1'b0;
            cur.scl_hold <= 1'b0;
            cur.brg_reload <= BRG_RESET;
            cur.brg_load <= 1'b0;
            cur.brg_run <= 1'b0;
            cur.tx_buf <= TXBUF_RESET;
            cur.status <= '0;
            cur.mask <= MASK_RESET;
            cur.irq <= 1'b0;
            cur.scl_rel <= 1'b1;
            cur.sda_rel <= 1'b1;
            cur.pin_level <= 1'b0;
            cur.waitreq <= 1'b1;
            cur.rdata <= RDATA_RESET;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // Every output comes straight from a register
    assign avs_readdata = cur.rdata;
    assign avs_waitrequest = cur.waitreq;
    assign irq = cur.irq;
    assign scl_out = cur.pin_level;
    assign sda_out = cur.pin_level;
    assign scl_oe_n = cur.scl_rel;
    assign sda_oe_n = cur.sda_rel;
endmodule

// file: testbench/imass_top_sva.sv
// Purpose: port-level checks of the two-wire ack/stop sequencer
// Assumes: one clock domain; the divider reload is followed from bus writes
// Notes: phase checks are lower bounds, since stretching may lengthen any phase
`timescale 1ns/100ps
module imass_top_sva
    import imass_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [imass_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [imass_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [imass_pkg::DATA_W-1:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic irq,
    input wire logic byte_done,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe_n,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe_n
);
    logic [BRG_W-1:0] reload_h;
    logic [ST_W-1:0] mask_h;
    logic ack_h;
    logic wr_ok;
    logic sda_q;
    int unsigned pres_cnt;
    int unsigned hi_cnt;
    int unsigned rel_cnt;
    assign wr_ok = avs_write && !avs_waitrequest;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            reload_h <= BRG_RESET;
            mask_h <= MASK_RESET;
            ack_h <= 1'b0;
            sda_q <= 1'b1;
            pres_cnt <= 0;
            hi_cnt <= 0;
            rel_cnt <= 0;
        end
        else
        begin
            if (wr_ok && avs_address == OFS_BRG)
                reload_h <= avs_writedata[BRG_W-1:0];
            if (wr_ok && avs_address == OFS_MASK)
                mask_h <= avs_writedata[ST_W-1:0];
            if (wr_ok && avs_address == OFS_CONTROL)
                ack_h <= avs_writedata[CTL_ACK_DATA];
            // Counts from the last data line change, when the ack bit is presented
            sda_q <= sda_oe_n;
            pres_cnt <= (sda_oe_n != sda_q) ? 0 : pres_cnt + 1;
            rel_cnt <= scl_oe_n ? rel_cnt + 1 : 0;
            hi_cnt <= (scl_oe_n && scl_in) ? hi_cnt + 1 : 0;
        end
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!reset_n);
    AST_PULL_ONLY: assert property (!scl_out && !sda_out)
        else $error("line driven high");
    AST_ACK_PRESENT: assert property (wr_ok && avs_address == OFS_CONTROL
        && avs_writedata[CTL_ACK_START] |-> ##[1:2] (!scl_oe_n && sda_oe_n == ack_h))
        else $error("ack bit not presented");
    AST_ACK_RELEASE: assert property ($rose(scl_oe_n)
        |-> pres_cnt >= 32'(reload_h) + 1)
        else $error("clock released too early");
    AST_HIGH_TIME: assert property ($fell(scl_oe_n)
        |-> hi_cnt >= 32'(reload_h) + 1)
        else $error("clock pulled low too early");
    AST_HOLD_BYTE: assert property (byte_done && scl_oe_n && sda_oe_n
        |-> ##[1:3] !scl_oe_n)
        else $error("clock not held after byte");
    AST_DATA_LOW: assert property ($fell(sda_oe_n) |-> !scl_oe_n)
        else $error("data pulled while clock released");
    AST_STOP_EDGE: assert property ($rose(sda_oe_n) && scl_oe_n
        |-> rel_cnt >= 32'(reload_h) + 1)
        else $error("data released too early");
    AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest
        |-> ##[1:2] (!avs_waitrequest ##1 avs_waitrequest))
        else $error("bus answer out of time");
    AST_IRQ_MASKED: assert property ($stable(mask_h) && mask_h == 3'h0 |=> !irq)
        else $error("masked interrupt raised");
    COV_ACK: cover property ($fell(scl_oe_n) && !sda_oe_n);
    COV_STOP: cover property ($rose(sda_oe_n) && scl_oe_n);
    COV_IRQ: cover property ($rose(irq));
endmodule

bind imass_top imass_top_sva u_sva (.sys_clk(sys_clk), .reset_n(reset_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .byte_done(byte_done),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n));

// file: testbench/imass_bus_model.sv
// Purpose: far-side slaves and pull-ups of the two-wire bus
// Assumes: open-drain lines, released level is high
// Notes: a slave may stretch each clock release by a set number of cycles
`timescale 1ns/100ps
module imass_bus_model
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic scl_oe_n,
    input wire logic sda_oe_n,
    input wire logic [7:0] stretch,
    output logic scl_in,
    output logic sda_in
);
    logic [7:0] hold_cnt;
    logic scl_q;
    logic grab;
    // Grab in the release cycle itself so no one-cycle high glitch leaks out
    assign grab = scl_oe_n && !scl_q && stretch != 8'h00;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            hold_cnt <= 8'h00;
            scl_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_oe_n;
            if (grab)
                hold_cnt <= stretch;
            else if (hold_cnt != 8'h00)
                hold_cnt <= hold_cnt - 8'h01;
        end
    end
    assign scl_in = scl_oe_n && !grab && hold_cnt == 8'h00;
    assign sda_in = sda_oe_n;
endmodule

// file: testbench/test_i2c_master_ack_stop_sequencer.sv
// Purpose: self-checking bench of the ack/stop sequencer
// Assumes: bus model on the lines, fixed seed for divider and stretch draws
// Notes: bus answers are taken at the rising edge that sees waitrequest low
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end
module test_i2c_master_ack_stop_sequencer;
    import imass_pkg::*;
    logic sys_clk;
    logic reset_n;
    logic [ADDR_W-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [DATA_W-1:0] avs_writedata;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic irq;
    logic byte_done;
    logic scl_in;
    logic scl_oe_n;
    logic sda_in;
    logic sda_oe_n;
    logic [7:0] stretch;
    logic [DATA_W-1:0] rd;
    logic [TXB_W-1:0] txv;
    int n_errors;
    int cmp_count;
    int cycles;
    int unsigned seed_val;
    imass_top uut (.sys_clk(sys_clk), .reset_n(reset_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
        .byte_done(byte_done), .scl_in(scl_in), .scl_out(), .scl_oe_n(scl_oe_n),
        .sda_in(sda_in), .sda_out(), .sda_oe_n(sda_oe_n));
    imass_bus_model u_bus (.sys_clk(sys_clk), .reset_n(reset_n), .scl_oe_n(scl_oe_n),
        .sda_oe_n(sda_oe_n), .stretch(stretch), .scl_in(scl_in), .sda_in(sda_in));
    initial
    begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            end_sim();
        end
    end
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge sys_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge sys_clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic wait_clear(input int b);
        int k;
        k = 0;
        do
        begin
            bus(1'b0, OFS_CONTROL, '0);
            k++;
        end
        while (rd[b] !== 1'b0 && k < 100);
    endtask
    initial
    begin
        reset_n = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        byte_done = 1'b0;
        stretch = 8'h00;
        seed_val = $urandom(32'h505E);
        repeat (12) @(posedge sys_clk);
        reset_n <= 1'b1;
        bus(1'b0, OFS_BRG, '0);
        `CHK(rd, {16'h0000, BRG_RESET})
        bus(1'b0, OFS_MASK, '0);
        `CHK(rd, 32'h00000000)
        bus(1'b0, 5'h14, '0);
        `CHK(rd, 32'h00000000)
        $display("test reset values done");
        bus(1'b1, OFS_BRG, 32'($urandom_range(6, 3)));
        bus(1'b1, OFS_MASK, 32'h00000007);
        txv = 8'($urandom);
        bus(1'b1, OFS_TXBUF, {24'h000000, txv});
        @(posedge sys_clk);
        byte_done <= 1'b1;
        @(posedge sys_clk);
        byte_done <= 1'b0;
        repeat (3) @(negedge sys_clk);
        `CHK(scl_oe_n, 1'b0)
        bus(1'b0, OFS_CONTROL, '0);
        `CHK(rd[CTL_SCL_HOLD], 1'b1)
        for (int ad = 0; ad < 2; ad++)
        begin
            stretch <= 8'($urandom_range(6, 0));
            bus(1'b1, OFS_CONTROL, 32'(ad << CTL_ACK_DATA));
            bus(1'b1, OFS_CONTROL, 32'((ad << CTL_ACK_DATA) | 1));
            repeat (2) @(negedge sys_clk);
            `CHK(scl_oe_n, 1'b0)
            `CHK(sda_in, ad[0])
            bus(1'b1, OFS_TXBUF, {24'h000000, ~txv});
            wait_clear(CTL_ACK_START);
            `CHK(rd[CTL_BUSY], 1'b0)
            `CHK(scl_oe_n, 1'b0)
            bus(1'b0, OFS_TXBUF, '0);
            `CHK(rd, {24'h000000, txv})
            bus(1'b0, OFS_STATUS, '0);
            `CHK(rd[ST_WRITE_COLLISION_FLAG], 1'b1)
            bus(1'b1, OFS_STATUS, 32'h00000007);
            bus(1'b0, OFS_STATUS, '0);
            `CHK(rd, 32'h00000000)
            $display("test ack value %0d done", ad);
        end
        bus(1'b1, OFS_CONTROL, 32'h00000006);
        bus(1'b1, OFS_TXBUF, {24'h000000, ~txv});
        wait_clear(CTL_STOP_START);
        bus(1'b0, OFS_STATUS, '0);
        `CHK(rd[ST_STOP], 1'b1)
        `CHK(rd[ST_SIRQ], 1'b1)
        `CHK(rd[ST_WRITE_COLLISION_FLAG], 1'b1)
        `CHK(irq, 1'b1)
        `CHK(scl_in, 1'b1)
        `CHK(sda_in, 1'b1)
        bus(1'b0, OFS_TXBUF, '0);
        `CHK(rd, {24'h000000, txv})
        bus(1'b1, OFS_MASK, 32'h00000000);
        repeat (2) @(negedge sys_clk);
        `CHK(irq, 1'b0)
        bus(1'b1, OFS_STATUS, 32'h00000007);
        bus(1'b0, OFS_STATUS, '0);
        `CHK(rd, 32'h00000000)
        $display("test stop done");
        end_sim();
    end
endmodule
